/* inc/fvsr_pkg.sv */
/*
  Constants for the volatile status register one block: command codes,
  bit positions and embedded operation kinds.
  Assumes a mode 0 serial command interface with 24-bit addresses.
*/
package fvsr_pkg;
  // Command codes
  localparam logic [7:0] OP_STATUS_ONE_READ_CMD = 8'h05;
  localparam logic [7:0] OP_STATUS_TWO_READ_CMD = 8'h07;
  localparam logic [7:0] OP_ANY_REGISTER_READ_CMD = 8'h65;
  localparam logic [7:0] OP_WRR = 8'h01;
  localparam logic [7:0] OP_ANY_REGISTER_WRITE_CMD = 8'h71;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_CLEAR_STATUS_CMD_A = 8'h30;
  localparam logic [7:0] OP_CLEAR_STATUS_CMD_B = 8'h82;
  localparam logic [7:0] OP_ESUSP = 8'h75;
  localparam logic [7:0] OP_PSUSP = 8'h85;
  // Bit positions of volatile_status_one
  localparam int BIT_STATUS_WRITE_DISABLE_COPY = 7;
  localparam int BIT_PERR = 6;
  localparam int BIT_EERR = 5;
  localparam int BIT_BP_HI = 4;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_BUSY = 0;
  // Byte counts of complete commands, byte counter cap, last bit index and zero values
  localparam logic [2:0] NB_WRR = 3'h2;
  localparam logic [2:0] NB_ADDR = 3'h4;
  localparam logic [2:0] NB_ADDR_DATA = 3'h5;
  localparam logic [2:0] NB_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BP_ZERO = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [2:0] {OPK_NONE, OPK_PROG, OPK_ERASE, OPK_BULK, OPK_NVWR} fvsr_op_t;
endpackage

/* verilog/fvsr_status_one.sv */
/*
  Volatile status register one of a serial flash: serial command front end,
  write enable latch, busy flag, sticky error flags and block protect bits.
  Assumes the array engine, the non-volatile image and the protected-range
  decoder sit outside on clk_sys_i; serial pins arrive asynchronously.
*/
`timescale 1ns/10ps
`default_nettype none
module fvsr_status_one #(
  parameter logic [23:0] VOLATILE_STATUS_ONE_ADDR = 24'h800000,
  parameter logic [7:0] OP_PROG = 8'h02,
  parameter logic [7:0] OP_ERASE = 8'hD8,
  parameter logic [7:0] OP_BULK = 8'h60,
  parameter logic [7:0] OP_SRST = 8'hF0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  // Non-volatile image and configuration
  input wire logic status_write_disable_nv_i,
  input wire logic [2:0] nv_block_protect_i,
  input wire logic protect_volatility_select_i,
  input wire logic [7:0] status_two_i,
  output logic nv_bp_write_o,
  output logic [2:0] nv_bp_o,
  // Array engine and protection decoder
  input wire logic prot_hit_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  output logic prog_start_o,
  output logic erase_start_o,
  output logic bulk_start_o,
  output logic erase_suspend_o,
  output logic program_suspend_o,
  output logic soft_reset_o,
  output logic [23:0] addr_o,
  // Status view
  output logic [7:0] volatile_status_one_o,
  output logic [2:0] block_protect_o
);
  typedef struct packed {
    logic [2:0] sck;
    logic [2:0] cs;
    logic [1:0] si;
    logic [1:0] wp;
    logic [7:0] sh;
    logic [2:0] bits;
    logic [2:0] nbytes;
    logic [7:0] opc;
    logic [23:0] addr;
    logic [7:0] wdat;
    logic [7:0] osh;
    logic so;
    logic so_oe;
    logic write_enable_latch;
    logic busy;
    logic perr;
    logic eerr;
    logic [2:0] bp;
    fvsr_pkg::fvsr_op_t op;
    logic prog_start;
    logic erase_start;
    logic bulk_start;
    logic nv_wr;
    logic [2:0] nv_bp;
    logic ers_susp;
    logic prg_susp;
    logic srst;
    logic [7:0] status;
    logic [2:0] bp_eff;
  } fvsr_state_t;

  fvsr_state_t q;
  fvsr_state_t d;
  logic sck_rise;
  logic sck_fall;
  logic cs_end;
  logic cmd_end;
  logic busy_ok;
  logic wlock;
  logic [7:0] sr1;

  assign sck_rise = q.sck[1] & ~q.sck[2];
  assign sck_fall = ~q.sck[1] & q.sck[2];
  assign cs_end = q.cs[1] & ~q.cs[2];
  // Only whole bytes count; a frame cut mid-byte does nothing
  assign cmd_end = cs_end && q.bits == 3'h0 && q.nbytes != 3'h0;
  assign busy_ok = q.opc inside {fvsr_pkg::OP_CLEAR_STATUS_CMD_A, fvsr_pkg::OP_CLEAR_STATUS_CMD_B, fvsr_pkg::OP_ESUSP,
                                 fvsr_pkg::OP_PSUSP, OP_SRST};
  assign wlock = status_write_disable_nv_i & ~q.wp[1];
  assign sr1 = {status_write_disable_nv_i, q.perr, q.eerr, q.bp, q.write_enable_latch, q.busy};

  always_comb
  begin
    logic [7:0] byte_in;
    logic [7:0] rd_op;
    logic [23:0] addr_n;
    logic go;
    logic wr_ok;
    byte_in = {q.sh[6:0], q.si[1]};
    rd_op = (q.nbytes == 3'h0) ? byte_in : q.opc;
    addr_n = (q.nbytes >= 3'h1 && q.nbytes <= 3'h3) ? {q.addr[15:0], byte_in} : q.addr;
    go = cmd_end && (!q.busy || busy_ok);
    wr_ok = 1'b0;
    d = q;
    d.sck = {q.sck[1:0], sck_i};
    d.cs = {q.cs[1:0], cs_n_i};
    d.si = {q.si[0], si_i};
    d.wp = {q.wp[0], wp_n_i};
    d.prog_start = 1'b0;
    d.erase_start = 1'b0;
    d.bulk_start = 1'b0;
    d.nv_wr = 1'b0;
    d.ers_susp = 1'b0;
    d.prg_susp = 1'b0;
    d.srst = 1'b0;
    // Copy follows the image when the protect bits are non-volatile, except while our own image write is pending
    if (!protect_volatility_select_i && q.op != fvsr_pkg::OPK_NVWR)
      d.bp = nv_block_protect_i;
    if (q.cs[1])
    begin
      d.bits = 3'h0;
      d.nbytes = 3'h0;
      d.so_oe = 1'b0;
    end
    else if (sck_rise)
    begin
      d.sh = byte_in;
      d.bits = q.bits + 3'h1;
      if (q.bits == fvsr_pkg::BIT_LAST)
      begin
        if (q.nbytes != fvsr_pkg::NB_MAX)
          d.nbytes = q.nbytes + 3'h1;
        if (q.nbytes == 3'h0)
          d.opc = byte_in;
        if (q.nbytes >= 3'h1 && q.nbytes <= 3'h3)
          d.addr = addr_n;
        if ((q.nbytes == 3'h1 && q.opc == fvsr_pkg::OP_WRR) || q.nbytes == 3'h4)
          d.wdat = byte_in;
        // Next byte out is loaded here and leaves on the following falls
        if (rd_op == fvsr_pkg::OP_STATUS_ONE_READ_CMD)
        begin
          d.osh = sr1;
          d.so_oe = 1'b1;
        end
        else if (rd_op == fvsr_pkg::OP_STATUS_TWO_READ_CMD)
        begin
          d.osh = status_two_i;
          d.so_oe = 1'b1;
        end
        else if (rd_op == fvsr_pkg::OP_ANY_REGISTER_READ_CMD && q.nbytes >= 3'h3)
        begin
          d.osh = (addr_n == VOLATILE_STATUS_ONE_ADDR) ? sr1 : fvsr_pkg::READ_ZERO;
          d.so_oe = 1'b1;
        end
      end
    end
    else if (sck_fall)
    begin
      d.so = q.osh[7];
      d.osh = {q.osh[6:0], 1'b0};
    end
    if (go)
    begin
      wr_ok = q.write_enable_latch && !wlock;
      if (q.opc == fvsr_pkg::OP_WRITE_ENABLE_CMD)
        d.write_enable_latch = 1'b1;
      else if (q.opc == fvsr_pkg::OP_WRITE_DISABLE_CMD)
        d.write_enable_latch = 1'b0;
      else if (q.opc == fvsr_pkg::OP_CLEAR_STATUS_CMD_A || q.opc == fvsr_pkg::OP_CLEAR_STATUS_CMD_B)
      begin
        d.perr = 1'b0;
        d.eerr = 1'b0;
        if (q.perr || q.eerr)
        begin
          d.busy = 1'b0;
          d.op = fvsr_pkg::OPK_NONE;
        end
      end
      else if (q.opc == fvsr_pkg::OP_ESUSP)
        d.ers_susp = q.busy && (q.op == fvsr_pkg::OPK_ERASE || q.op == fvsr_pkg::OPK_BULK);
      else if (q.opc == fvsr_pkg::OP_PSUSP)
        d.prg_susp = q.busy && q.op == fvsr_pkg::OPK_PROG;
      else if (q.opc == OP_SRST)
      begin
        d.srst = 1'b1;
        d.write_enable_latch = 1'b0;
        d.busy = 1'b0;
        d.perr = 1'b0;
        d.eerr = 1'b0;
        d.op = fvsr_pkg::OPK_NONE;
      end
      else if (wr_ok && ((q.opc == fvsr_pkg::OP_WRR && q.nbytes >= fvsr_pkg::NB_WRR) ||
               (q.opc == fvsr_pkg::OP_ANY_REGISTER_WRITE_CMD && q.nbytes >= fvsr_pkg::NB_ADDR_DATA && q.addr == VOLATILE_STATUS_ONE_ADDR)))
      begin
        // Only bits 4:2 take write data; flags keep theirs; the latch clears if volatile, else busy sets for the image write
        d.bp = q.wdat[fvsr_pkg::BIT_BP_HI:fvsr_pkg::BIT_BP_LO];
        if (protect_volatility_select_i)
          d.write_enable_latch = 1'b0;
        else
        begin
          d.nv_wr = 1'b1;
          d.nv_bp = q.wdat[fvsr_pkg::BIT_BP_HI:fvsr_pkg::BIT_BP_LO];
          d.busy = 1'b1;
          d.op = fvsr_pkg::OPK_NVWR;
        end
      end
      else if (q.write_enable_latch && q.opc == OP_PROG && q.nbytes >= fvsr_pkg::NB_ADDR_DATA)
      begin
        d.busy = 1'b1;
        d.op = fvsr_pkg::OPK_PROG;
        if (prot_hit_i)
          d.perr = 1'b1;
        else
          d.prog_start = 1'b1;
      end
      else if (q.write_enable_latch && q.opc == OP_ERASE && q.nbytes >= fvsr_pkg::NB_ADDR)
      begin
        d.busy = 1'b1;
        d.op = fvsr_pkg::OPK_ERASE;
        if (prot_hit_i)
          d.eerr = 1'b1;
        else
          d.erase_start = 1'b1;
      end
      else if (q.write_enable_latch && q.opc == OP_BULK && q.bp_eff == fvsr_pkg::BP_ZERO)
      begin
        // Protected sectors met inside are skipped by the engine, no error
        d.bulk_start = 1'b1;
        d.busy = 1'b1;
        d.op = fvsr_pkg::OPK_BULK;
      end
    end
    // Completion after clear-status so a same-cycle error still lands
    if (q.busy && op_done_i && q.op != fvsr_pkg::OPK_NONE && !d.srst)
    begin
      if (op_fail_i)
      begin
        // Latch may stay set after a failure; the host clears it
        if (q.op == fvsr_pkg::OPK_ERASE || q.op == fvsr_pkg::OPK_BULK)
          d.eerr = 1'b1;
        else
          d.perr = 1'b1;
      end
      else if (!q.perr && !q.eerr)
      begin
        d.busy = 1'b0;
        d.write_enable_latch = 1'b0;
        d.op = fvsr_pkg::OPK_NONE;
      end
    end
    d.bp_eff = protect_volatility_select_i ? d.bp : nv_block_protect_i;
    d.status = {status_write_disable_nv_i, d.perr, d.eerr, d.bp, d.write_enable_latch, d.busy};
    if (rst_i)
    begin
      d = '0;
      d.bp = nv_block_protect_i;
      d.cs = 3'h7; // Idle level, else a false frame end follows reset
      d.status = {status_write_disable_nv_i, 2'h0, nv_block_protect_i, 2'h0};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    q <= d;
  end

  assign so_o = q.so;
  assign so_oe_o = q.so_oe;
  assign nv_bp_write_o = q.nv_wr;
  assign nv_bp_o = q.nv_bp;
  assign prog_start_o = q.prog_start;
  assign erase_start_o = q.erase_start;
  assign bulk_start_o = q.bulk_start;
  assign erase_suspend_o = q.ers_susp;
  assign program_suspend_o = q.prg_susp;
  assign soft_reset_o = q.srst;
  assign addr_o = q.addr;
  assign volatile_status_one_o = q.status;
  assign block_protect_o = q.bp_eff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_write_enable_cmd_sets_latch: assert property (cmd_end && !q.busy && q.opc == fvsr_pkg::OP_WRITE_ENABLE_CMD |=> q.write_enable_latch)
    else $error("write enable did not set latch");
  a_write_disable_cmd_clears_latch: assert property (cmd_end && !q.busy && q.opc == fvsr_pkg::OP_WRITE_DISABLE_CMD |=> !q.write_enable_latch)
    else $error("write disable did not clear latch");
  a_error_sticky: assert property (q.perr && !(cmd_end && busy_ok) |=> q.perr)
    else $error("program error dropped without clear");
  a_error_holds_busy: assert property (q.perr || q.eerr |-> q.busy)
    else $error("error flag set while not busy");
  a_bulk_needs_zero: assert property (bulk_start_o |-> $past(q.bp_eff) == 3'h0)
    else $error("whole erase started with protection set");
  a_start_needs_wel: assert property (prog_start_o || erase_start_o || bulk_start_o |-> $past(q.write_enable_latch))
    else $error("operation started with latch clear");
  a_copy_bit: assert property (volatile_status_one_o[7] == $past(status_write_disable_nv_i))
    else $error("write disable copy stale");
  a_done_clears: assert property (q.busy && op_done_i && !op_fail_i && !q.perr && !q.eerr
    && q.op != fvsr_pkg::OPK_NONE && !cmd_end |=> !q.write_enable_latch && !q.busy)
    else $error("successful end left latch or busy");
  a_busy_filters: assert property (cmd_end && q.busy && q.opc == OP_PROG |=> !prog_start_o)
    else $error("program accepted while busy");
  a_lock_blocks: assert property (nv_bp_write_o |-> $past(q.write_enable_latch) && !$past(wlock))
    else $error("register write passed lock");
  a_prot_refused: assert property (prog_start_o |-> !$past(prot_hit_i))
    else $error("program started on protected area");

  c_status_read: cover property (cmd_end && q.opc == fvsr_pkg::OP_STATUS_ONE_READ_CMD);
  c_prog_done: cover property (q.op == fvsr_pkg::OPK_PROG && op_done_i ##1 !q.busy);
  c_err_cleared: cover property (q.eerr ##[1:200] !q.eerr);
  c_nv_write: cover property (nv_bp_write_o);
endmodule
`default_nettype wire

/* verification/fvsr_host.sv */
/*
  Host serial controller model for the status register one block.
  Assumes the caller times frames; mode 0, sck 12 clk per bit (48 ns).
*/
`timescale 1ns/10ps
`default_nettype none
module fvsr_host (
  // Clock
  input wire logic clk_sys_i,
  // Serial pins
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Whole bytes MSB first; rx holds the last byte seen on so
  task automatic frame(input logic [39:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    wt(1);
    cs_n_o = 1'b0;
    for (int i = n * 8 - 1; i >= 0; i--)
    begin
      si_o = tx[i];
      wt(6);
      sck_o = 1'b1;
      rx = {rx[6:0], so_oe_i ? so_i : ~rx[0]};
      wt(6);
      sck_o = 1'b0;
    end
    wt(6);
    cs_n_o = 1'b1;
    // Released line must not keep showing the last bit
    si_o = ~si_o;
    wt(12);
  endtask
endmodule
`default_nettype wire

/* verification/test_fvsr_status_one.sv */
/*
  Testbench for the volatile status register one block: command sequences
  through the host model, engine inputs driven here.
  Assumes default command code parameters of the design.
*/
`timescale 1ns/10ps
`default_nettype none
module test_fvsr_status_one;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, sck, cs_n, si, so, so_oe;
  logic wp_n_i = 1'b1, wd_nv = 1'b0, sel = 1'b0, prot = 1'b0, done_i = 1'b0, fail_i = 1'b0;
  logic [2:0] nvbp = 3'h0, nvv, bp_o, nbo;
  logic [7:0] st;
  logic ps, es, bs, esu, psu, nw, sr;
  logic [23:0] ad;
  int fails = 0, n_tests = 0, pc = 0, ec = 0, bc = 0, esc = 0, psc = 0, nwc = 0, src = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  fvsr_host i_fvsr_host (.clk_sys_i(clk_sys_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
    .so_oe_i(so_oe));
  fvsr_status_one i_fvsr_status_one (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .status_write_disable_nv_i(wd_nv),
    .nv_block_protect_i(nvbp), .protect_volatility_select_i(sel), .status_two_i(8'h5A),
    .nv_bp_write_o(nw), .nv_bp_o(nbo), .prot_hit_i(prot), .op_done_i(done_i), .op_fail_i(fail_i),
    .prog_start_o(ps), .erase_start_o(es), .bulk_start_o(bs), .erase_suspend_o(esu),
    .program_suspend_o(psu), .soft_reset_o(sr), .addr_o(ad), .volatile_status_one_o(st),
    .block_protect_o(bp_o));
  // Pulse counters so refused commands show as a missing pulse
  always @(posedge clk_sys_i)
  begin
    pc += ps;
    ec += es;
    bc += bs;
    esc += esu;
    psc += psu;
    nwc += nw;
    src += sr;
    if (nw === 1'b1)
      nvv <= nbo;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(input logic [39:0] tx, input int n);
    logic [7:0] r;
    i_fvsr_host.frame(tx, n, r);
  endtask
  task automatic rd(input logic [7:0] e, input logic [39:0] tx = 40'h0500, input int n = 2);
    logic [7:0] r;
    i_fvsr_host.frame(tx, n, r);
    chk("status", e, r);
  endtask
  task automatic done(input logic f);
    @(posedge clk_sys_i) #1;
    done_i = 1'b1;
    fail_i = f;
    @(posedge clk_sys_i) #1;
    done_i = 1'b0;
    fail_i = 1'b0;
    i_fvsr_host.wt(4);
  endtask
  localparam logic [39:0] PROG = {8'h02, 24'h001000, 8'hA5}, ERAS = {8'h00, 8'hD8, 24'h001000};
  initial
  begin
    // About four times the expected run, well under the cycle budget
    #200us;
    fails++;
    end_sim();
  end
  initial
  begin
    int c;
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    i_fvsr_host.wt(6);
    rd(8'h00);
    chk("view", 8'h00, st);
    rd(8'h00, {8'h65, 24'h800000, 8'h00}, 5);
    cmd(40'h06, 1);
    rd(8'h02);
    cmd(40'h04, 1);
    rd(8'h00);
    c = nwc;
    cmd(40'h011C, 2);
    chk("nvwr", 8'(c), 8'(nwc));
    // Protected program then protected erase, each cleared by one opcode
    for (int k = 0; k < 2; k++)
    begin
      prot = 1'b1;
      c = pc + ec;
      cmd(40'h06, 1);
      cmd(k ? ERAS : PROG, k ? 4 : 5);
      chk("start", 8'(c), 8'(pc + ec));
      rd(k ? 8'h23 : 8'h43);
      cmd(40'h04, 1);
      rd(k ? 8'h23 : 8'h43);
      cmd(k ? 40'h82 : 40'h30, 1);
      rd(8'h02);
      cmd(40'h04, 1);
      rd(8'h00);
      prot = 1'b0;
    end
    cmd(40'h06, 1);
    c = pc;
    cmd(PROG, 5);
    chk("prog", 8'(c + 1), 8'(pc));
    chk("addr", 8'h10, ad[15:8]);
    rd(8'h03);
    rd(8'h5A, 40'h0700);
    cmd(PROG, 5);
    chk("busy prog", 8'(c + 1), 8'(pc));
    c = esc;
    cmd(40'h75, 1);
    chk("esusp", 8'(c), 8'(esc));
    c = psc;
    cmd(40'h85, 1);
    chk("psusp", 8'(c + 1), 8'(psc));
    done(1'b0);
    rd(8'h00);
    cmd(40'h06, 1);
    c = ec;
    cmd(ERAS, 4);
    chk("erase", 8'(c + 1), 8'(ec));
    c = esc;
    cmd(40'h75, 1);
    chk("esusp", 8'(c + 1), 8'(esc));
    done(1'b1);
    rd(8'h23);
    c = src;
    cmd(40'hF0, 1);
    chk("srst", 8'(c + 1), 8'(src));
    rd(8'h00);
    cmd(40'h06, 1);
    c = bc;
    cmd(40'h60, 1);
    chk("bulk", 8'(c + 1), 8'(bc));
    done(1'b0);
    rd(8'h00);
    sel = 1'b1;
    c = nwc;
    cmd(40'h06, 1);
    cmd(40'h01FF, 2);
    rd(8'h1C);
    chk("nvwr", 8'(c), 8'(nwc));
    chk("bp", 8'h07, 8'(bp_o));
    cmd(40'h06, 1);
    c = bc;
    cmd(40'h60, 1);
    chk("bulk", 8'(c), 8'(bc));
    cmd(40'h04, 1);
    wd_nv = 1'b1;
    wp_n_i = 1'b0;
    rd(8'h9C);
    cmd(40'h06, 1);
    cmd(40'h0100, 2);
    rd(8'h9E);
    chk("view", 8'h9E, st);
    wd_nv = 1'b0;
    wp_n_i = 1'b1;
    rd(8'h1E, {8'h65, 24'h800000, 8'h00}, 5);
    cmd({8'h71, 24'h800000, 8'h00}, 5);
    rd(8'h00, {8'h65, 24'h800000, 8'h00}, 5);
    sel = 1'b0;
    c = nwc;
    cmd(40'h06, 1);
    cmd(40'h0108, 2);
    chk("nvwr", 8'(c + 1), 8'(nwc));
    chk("nvbp", 8'h02, 8'(nvv));
    nvbp = 3'h2;
    done(1'b0);
    rd(8'h08);
    end_sim();
  end
endmodule
`default_nettype wire
